// ==== core/trc_pkg.sv ====
// Purpose: Constants and types for the repetition and capture timer unit
// Assumes: Registers sit at word-aligned byte addresses on a plain port
// Notes:   Bit positions are the low bit of each field
package trc_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte addresses
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_SLAVE = 8'h04;
	localparam logic [7:0] OFS_IEN   = 8'h08;
	localparam logic [7:0] OFS_STAT  = 8'h0c;
	localparam logic [7:0] OFS_EGEN  = 8'h10;
	localparam logic [7:0] OFS_CHCFG = 8'h14;
	localparam logic [7:0] OFS_CHEN  = 8'h18;
	localparam logic [7:0] OFS_CNT   = 8'h1c;
	localparam logic [7:0] OFS_PSC   = 8'h20;
	localparam logic [7:0] OFS_PER   = 8'h24;
	localparam logic [7:0] OFS_REP   = 8'h28;
	localparam logic [7:0] OFS_CH1   = 8'h2c;
	localparam logic [7:0] OFS_CH2   = 8'h30;

	// Control register
	localparam int B_CEN  = 0;
	localparam int B_DIR  = 1;
	localparam int B_CMS  = 2;
	localparam int B_URS  = 4;
	localparam int B_UDIS = 5;
	// Slave control register
	localparam int B_SMS = 0;
	localparam int B_TS  = 4;
	localparam int B_ECE = 7;
	localparam int B_ETP = 8;
	// Status, enable and event generation registers
	localparam int B_UIF = 0;
	localparam int B_CCF = 1;
	localparam int B_OVR = 9;
	localparam int B_UDE = 8;
	localparam int B_UG  = 0;
	localparam int B_CG  = 1;
	// Channel enable register, one nibble per channel, and channel config width
	localparam int B_CE      = 0;
	localparam int B_CP      = 1;
	localparam int CH_STRIDE = 4;
	localparam int CFG_W     = 8;

	// Mode encodings
	localparam logic [2:0] SMS_RESET = 3'h4;
	localparam logic [2:0] SMS_EXT1  = 3'h7;
	localparam logic [2:0] TS_EDGE1  = 3'h4;
	localparam logic [2:0] TS_TI1    = 3'h5;
	localparam logic [2:0] TS_TI2    = 3'h6;
	localparam logic [2:0] TS_ETR    = 3'h7;
	localparam logic [1:0] SEL_OUT   = 2'h0;
	localparam logic [1:0] SEL_OWN   = 2'h1;
	localparam logic [1:0] SEL_CROSS = 2'h2;
	localparam logic [1:0] SEL_TRG   = 2'h3;
	localparam logic [1:0] CMS_EDGE  = 2'h0;
	localparam logic [3:0] FLT_8     = 4'h3;

	typedef struct packed {
		logic [3:0] filt;
		logic [1:0] psc;
		logic [1:0] sel;
	} trc_chcfg_t;

	// Samples needed before a new input level is accepted
	function automatic logic [3:0] filt_len(input logic [3:0] code);
		unique case (code)
			4'h0: return 4'h1;
			4'h1: return 4'h2;
			4'h2: return 4'h4;
			default: return 4'h8;
		endcase
	endfunction : filt_len

endpackage : trc_pkg

// ==== core/trc_timer_core.sv ====
// Purpose: Time base with repetition counter, clock select and two
//          capture channels behind a plain register port
// Assumes: All inputs synchronous to CLK_SYS; filter samples at CLK_SYS
// Notes:   Compare output is a plain PWM reference only, edge or center aligned as the counting mode
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/10ps
module trc_timer_core #(
	parameter int CNT_W = 16,
	parameter int REP_W = 8
) (
	// Clock and reset
	input  wire logic                       CLK_SYS,
	input  wire logic                       ARST_N,
	// Register port
	input  wire logic [trc_pkg::ADDR_W-1:0] ADDR,
	input  wire logic [trc_pkg::DATA_W-1:0] WDATA,
	input  wire logic                       WR,
	input  wire logic                       RD,
	output logic      [trc_pkg::DATA_W-1:0] RDATA,
	// Channel inputs and trigger sources
	input  wire logic [1:0]                 TI,
	input  wire logic                       ETR_PIN,
	input  wire logic [3:0]                 ITRIG,
	// Events and requests
	output logic                            UPDATE_EVENT,
	output logic                            UPD_IRQ,
	output logic                            UPD_DMA,
	output logic      [1:0]                 CH_IRQ,
	output logic      [1:0]                 CH_DMA,
	output logic      [1:0]                 OC
);

	if (CNT_W < 2 || CNT_W > trc_pkg::DATA_W || REP_W != 8) begin : g_chk
		$error("trc_timer_core: unsupported width parameters");
	end

	typedef struct packed {
		logic                          count_enable, dir, update_request_select, udis;
		logic [1:0]                    cms;
		logic [2:0]                    slave_mode_select, ts;
		logic                          ece, etp;
		logic                          uie, ude;
		logic [1:0]                    cie, cde;
		logic                          update_flag;
		logic [1:0]                    ccif, ccof;
		trc_pkg::trc_chcfg_t [1:0]     cfg;
		logic [1:0]                    ce, cp;
		logic [CNT_W-1:0]              cnt, psc_pre, psc_sh, psc_cnt;
		logic [CNT_W-1:0]              per_pre, per_sh;
		logic [REP_W-1:0]              rep_val, rep_cnt;
		logic [1:0][CNT_W-1:0]         ccr_pre, ccr_sh;
		logic [1:0]                    filt;
		logic [1:0][3:0]               fcnt;
		logic [1:0][2:0]               ipsc;
		logic                          etr_prev;
		logic [3:0]                    itr_prev;
		logic [trc_pkg::DATA_W-1:0]    rdata;
		logic                          upd, upd_irq, upd_dma;
		logic [1:0]                    ch_irq, ch_dma, oc;
	} trc_state_t;

	trc_state_t q;
	trc_state_t n;

	logic                       sw_ug, slv_rst, force_upd, hw_upd;
	logic                       tick, step, ovf, unf, cnt_evt, trig;
	logic                       etr_edge, wr_egen;
	logic [1:0]                 sw_cg, rise, fall, ic, cap, match;
	logic [1:0][1:0]            fp;
	logic [1:0][2:0]            pmax;
	logic [trc_pkg::DATA_W-1:0] rd;

	always_comb begin
		n = q;
		n.upd = 1'b0;
		n.etr_prev = ETR_PIN;
		n.itr_prev = ITRIG;
		wr_egen = WR && (ADDR == trc_pkg::OFS_EGEN);
		// Self-clearing: event bits are never stored
		sw_ug = wr_egen && WDATA[trc_pkg::B_UG];
		sw_cg = wr_egen ? WDATA[trc_pkg::B_CG +: 2] : 2'h0;

		// Filters hold the old level until the run is long enough
		for (int i = 0; i < 2; i++) begin
			if (TI[i] == q.filt[i]) begin
				n.fcnt[i] = 4'h0;
			end else if (q.fcnt[i] + 4'h1 >=
			             trc_pkg::filt_len(q.cfg[i].filt)) begin
				n.filt[i] = TI[i];
				n.fcnt[i] = 4'h0;
			end else begin
				n.fcnt[i] = q.fcnt[i] + 4'h1;
			end
			rise[i] = n.filt[i] & ~q.filt[i];
			fall[i] = ~n.filt[i] & q.filt[i];
		end
		// fp[input][channel]: edge of an input with a channel's polarity
		for (int i = 0; i < 2; i++) begin
			for (int c = 0; c < 2; c++) begin
				fp[i][c] = q.cp[c] ? fall[i] : rise[i];
			end
		end

		etr_edge = q.etp ? (q.etr_prev & ~ETR_PIN)
		                 : (~q.etr_prev & ETR_PIN);
		unique case (q.ts)
			trc_pkg::TS_EDGE1: trig = rise[0] | fall[0];
			trc_pkg::TS_TI1:   trig = fp[0][0];
			trc_pkg::TS_TI2:   trig = fp[1][1];
			trc_pkg::TS_ETR:   trig = etr_edge;
			default:           trig = ITRIG[q.ts[1:0]] &
			                          ~q.itr_prev[q.ts[1:0]];
		endcase
		for (int c = 0; c < 2; c++) begin
			unique case (q.cfg[c].sel)
				trc_pkg::SEL_OUT:   ic[c] = 1'b0;
				trc_pkg::SEL_OWN:   ic[c] = fp[c][c];
				trc_pkg::SEL_CROSS: ic[c] = fp[1-c][c];
				trc_pkg::SEL_TRG:   ic[c] = trig;
			endcase
		end

		// Count clock source
		if (q.ece) begin
			tick = etr_edge;
		end else if (q.slave_mode_select == trc_pkg::SMS_EXT1) begin
			tick = trig;
		end else begin
			tick = 1'b1;
		end
		slv_rst = (q.slave_mode_select == trc_pkg::SMS_RESET) && trig;
		force_upd = sw_ug || slv_rst;
		step = q.count_enable && tick && (q.psc_cnt == q.psc_sh);
		if (q.count_enable && tick) begin
			n.psc_cnt = step ? '0 : q.psc_cnt + 1'b1;
		end
		ovf = 1'b0;
		unf = 1'b0;
		if (step) begin
			if (q.cms == trc_pkg::CMS_EDGE) begin
				if (!q.dir) begin
					if (q.cnt >= q.per_sh) begin
						n.cnt = '0;
						ovf = 1'b1;
					end else begin
						n.cnt = q.cnt + 1'b1;
					end
				end else if (q.cnt == '0) begin
					n.cnt = q.per_sh;
					unf = 1'b1;
				end else begin
					n.cnt = q.cnt - 1'b1;
				end
			end else if (!q.dir) begin
				if (CNT_W'(q.cnt + 1'b1) >= q.per_sh) begin
					n.cnt = q.per_sh;
					n.dir = 1'b1;
					ovf = 1'b1;
				end else begin
					n.cnt = q.cnt + 1'b1;
				end
			end else if (q.cnt <= CNT_W'(1)) begin
				n.cnt = '0;
				n.dir = 1'b0;
				unf = 1'b1;
			end else begin
				n.cnt = q.cnt - 1'b1;
			end
		end
		// Center mode gets both turning points, hence half the reach
		cnt_evt = ovf | unf;

		hw_upd = 1'b0;
		if (force_upd) begin
			n.rep_cnt = q.rep_val;
		end else if (cnt_evt) begin
			if (q.rep_cnt == '0) begin
				hw_upd = ~q.udis;
				n.rep_cnt = q.rep_val;
			end else begin
				n.rep_cnt = q.rep_cnt - 1'b1;
			end
		end
		if (force_upd || hw_upd) begin
			n.upd = 1'b1;
			n.per_sh = q.per_pre;
			n.psc_sh = q.psc_pre;
			for (int c = 0; c < 2; c++) begin
				if (q.cfg[c].sel == trc_pkg::SEL_OUT) begin
					n.ccr_sh[c] = q.ccr_pre[c];
				end
			end
		end
		if (force_upd) begin
			n.psc_cnt = '0;
			n.cnt = (q.cms == trc_pkg::CMS_EDGE && q.dir) ? q.per_pre : '0;
		end

		// Input prescaler counts accepted edges
		for (int c = 0; c < 2; c++) begin
			cap[c] = 1'b0;
			pmax[c] = 3'((4'h1 << q.cfg[c].psc) - 4'h1);
			match[c] = step && (q.cfg[c].sel == trc_pkg::SEL_OUT) &&
			           (q.cnt == q.ccr_sh[c]);
			if (!q.ce[c] || q.cfg[c].sel == trc_pkg::SEL_OUT) begin
				n.ipsc[c] = 3'h0;
			end else if (ic[c]) begin
				if (q.ipsc[c] == pmax[c]) begin
					cap[c] = 1'b1;
					n.ipsc[c] = 3'h0;
				end else begin
					n.ipsc[c] = q.ipsc[c] + 3'h1;
				end
			end
			if (cap[c]) begin
				n.ccr_sh[c] = q.cnt;
				n.ccr_pre[c] = q.cnt;
			end
			// Reference is active high below the compare value; cp inverts it here
			n.oc[c] = (q.cfg[c].sel == trc_pkg::SEL_OUT) && q.ce[c] &&
			          ((q.cnt < q.ccr_sh[c]) ^ q.cp[c]);
		end

		if (WR) begin
			unique case (ADDR)
				trc_pkg::OFS_CTRL: begin
					n.count_enable = WDATA[trc_pkg::B_CEN];
					if (q.cms == trc_pkg::CMS_EDGE) begin
						n.dir = WDATA[trc_pkg::B_DIR];
					end
					n.cms = WDATA[trc_pkg::B_CMS +: 2];
					n.update_request_select = WDATA[trc_pkg::B_URS];
					n.udis = WDATA[trc_pkg::B_UDIS];
				end
				trc_pkg::OFS_SLAVE: begin
					n.slave_mode_select = WDATA[trc_pkg::B_SMS +: 3];
					n.ts = WDATA[trc_pkg::B_TS +: 3];
					n.ece = WDATA[trc_pkg::B_ECE];
					n.etp = WDATA[trc_pkg::B_ETP];
				end
				trc_pkg::OFS_IEN: begin
					n.uie = WDATA[trc_pkg::B_UIF];
					n.cie = WDATA[trc_pkg::B_CCF +: 2];
					n.ude = WDATA[trc_pkg::B_UDE];
					n.cde = WDATA[trc_pkg::B_UDE + 1 +: 2];
				end
				trc_pkg::OFS_CHCFG:
					n.cfg = WDATA[2*trc_pkg::CFG_W-1:0];
				trc_pkg::OFS_CHEN: begin
					for (int c = 0; c < 2; c++) begin
						n.ce[c] = WDATA[c*trc_pkg::CH_STRIDE + trc_pkg::B_CE];
						n.cp[c] = WDATA[c*trc_pkg::CH_STRIDE + trc_pkg::B_CP];
					end
				end
				trc_pkg::OFS_CNT: n.cnt = WDATA[CNT_W-1:0];
				trc_pkg::OFS_PSC: n.psc_pre = WDATA[CNT_W-1:0];
				trc_pkg::OFS_PER: n.per_pre = WDATA[CNT_W-1:0];
				trc_pkg::OFS_REP: begin
					n.rep_val = WDATA[REP_W-1:0];
					// Stopped: phase counts from the start of counting
					if (!q.count_enable) begin
						n.rep_cnt = WDATA[REP_W-1:0];
					end
				end
				trc_pkg::OFS_CH1: begin
					if (q.cfg[0].sel == trc_pkg::SEL_OUT) begin
						n.ccr_pre[0] = WDATA[CNT_W-1:0];
					end
				end
				trc_pkg::OFS_CH2: begin
					if (q.cfg[1].sel == trc_pkg::SEL_OUT) begin
						n.ccr_pre[1] = WDATA[CNT_W-1:0];
					end
				end
				default: ;
			endcase
		end

		// Clears first, then sets, so a new event is never lost
		if (WR && ADDR == trc_pkg::OFS_STAT) begin
			n.update_flag = q.update_flag & WDATA[trc_pkg::B_UIF];
			n.ccif = q.ccif & WDATA[trc_pkg::B_CCF +: 2];
			n.ccof = q.ccof & WDATA[trc_pkg::B_OVR +: 2];
		end
		if (RD && ADDR == trc_pkg::OFS_CH1) begin
			n.ccif[0] = 1'b0;
		end
		if (RD && ADDR == trc_pkg::OFS_CH2) begin
			n.ccif[1] = 1'b0;
		end
		n.update_flag = n.update_flag | hw_upd | (force_upd & ~q.update_request_select);
		n.ccif = n.ccif | cap | sw_cg | match;
		n.ccof = n.ccof | (cap & q.ccif);
		n.upd_irq = n.update_flag & q.uie;
		n.upd_dma = n.update_flag & q.ude;
		n.ch_irq = n.ccif & q.cie;
		n.ch_dma = n.ccif & q.cde;

		rd = '0;
		unique case (ADDR)
			trc_pkg::OFS_CTRL: begin
				rd[trc_pkg::B_CEN] = q.count_enable;
				rd[trc_pkg::B_DIR] = q.dir;
				rd[trc_pkg::B_CMS +: 2] = q.cms;
				rd[trc_pkg::B_URS] = q.update_request_select;
				rd[trc_pkg::B_UDIS] = q.udis;
			end
			trc_pkg::OFS_SLAVE: begin
				rd[trc_pkg::B_SMS +: 3] = q.slave_mode_select;
				rd[trc_pkg::B_TS +: 3] = q.ts;
				rd[trc_pkg::B_ECE] = q.ece;
				rd[trc_pkg::B_ETP] = q.etp;
			end
			trc_pkg::OFS_IEN: begin
				rd[trc_pkg::B_UIF] = q.uie;
				rd[trc_pkg::B_CCF +: 2] = q.cie;
				rd[trc_pkg::B_UDE] = q.ude;
				rd[trc_pkg::B_UDE + 1 +: 2] = q.cde;
			end
			trc_pkg::OFS_STAT: begin
				rd[trc_pkg::B_UIF] = q.update_flag;
				rd[trc_pkg::B_CCF +: 2] = q.ccif;
				rd[trc_pkg::B_OVR +: 2] = q.ccof;
			end
			trc_pkg::OFS_CHCFG: rd[2*trc_pkg::CFG_W-1:0] = q.cfg;
			trc_pkg::OFS_CHEN: begin
				for (int c = 0; c < 2; c++) begin
					rd[c*trc_pkg::CH_STRIDE + trc_pkg::B_CE] = q.ce[c];
					rd[c*trc_pkg::CH_STRIDE + trc_pkg::B_CP] = q.cp[c];
				end
			end
			trc_pkg::OFS_CNT: rd[CNT_W-1:0] = q.cnt;
			trc_pkg::OFS_PSC: rd[CNT_W-1:0] = q.psc_pre;
			trc_pkg::OFS_PER: rd[CNT_W-1:0] = q.per_pre;
			trc_pkg::OFS_REP: rd[REP_W-1:0] = q.rep_val;
			trc_pkg::OFS_CH1: rd[CNT_W-1:0] = q.ccr_pre[0];
			trc_pkg::OFS_CH2: rd[CNT_W-1:0] = q.ccr_pre[1];
			default: rd = '0;
		endcase
		n.rdata = RD ? rd : '0;
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign RDATA = q.rdata;
	assign UPDATE_EVENT = q.upd;
	assign UPD_IRQ = q.upd_irq;
	assign UPD_DMA = q.upd_dma;
	assign CH_IRQ = q.ch_irq;
	assign CH_DMA = q.ch_dma;
	assign OC = q.oc;

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!ARST_N);

	a_rep_gate_upd: assert property (
		cnt_evt && !force_upd && q.rep_cnt != '0 |=> !q.upd)
		else $error("update issued with repetition count nonzero");
	a_rep_step_down: assert property (
		cnt_evt && !force_upd && q.rep_cnt != '0 && !WR
		|=> q.rep_cnt == $past(q.rep_cnt) - 1'b1)
		else $error("repetition counter did not step down");
	a_rep_auto_reload: assert property (
		cnt_evt && !force_upd && q.rep_cnt == '0 && !WR
		|=> q.rep_cnt == $past(q.rep_val) && q.upd == !$past(q.udis))
		else $error("repetition counter did not reload at zero");
	a_force_update_now: assert property (
		force_upd && !(WR && ADDR == trc_pkg::OFS_REP)
		|=> q.upd && q.rep_cnt == $past(q.rep_val))
		else $error("forced update not immediate");
	a_cap_latch_cnt: assert property (
		cap[0] |=> q.ccr_pre[0] == $past(q.cnt) && q.ccif[0])
		else $error("capture did not latch counter and flag");
	a_overcap_set: assert property (
		cap[1] && q.ccif[1] |=> q.ccof[1])
		else $error("overcapture flag not set");
	a_ovr_hold_flag: assert property (
		q.ccof[0] && !(WR && ADDR == trc_pkg::OFS_STAT) |=> q.ccof[0])
		else $error("overcapture flag cleared without a write");
	a_read_clear_flag: assert property (
		RD && ADDR == trc_pkg::OFS_CH1 && !cap[0] && !match[0] &&
		!sw_cg[0] |=> !q.ccif[0])
		else $error("reading channel value did not clear flag");
	a_cap_needs_en: assert property (
		!q.ce[0] |-> !cap[0])
		else $error("capture while channel disabled");
	a_input_read_only: assert property (
		WR && ADDR == trc_pkg::OFS_CH1 &&
		q.cfg[0].sel != trc_pkg::SEL_OUT && !cap[0]
		|=> $stable(q.ccr_pre[0]))
		else $error("input channel value was written");
	a_filter_eight: assert property (
		$rose(q.filt[0]) && $past(q.cfg[0].filt) == trc_pkg::FLT_8
		|-> $past(TI[0], 1) && $past(TI[0], 8))
		else $error("filter accepted level before eight samples");
	a_urs_no_flag: assert property (
		sw_ug && q.update_request_select && !q.update_flag && !cnt_evt |=> !q.update_flag)
		else $error("update flag set by selected soft update");
	a_slave_reset_cnt: assert property (
		slv_rst && !WR && (q.cms != trc_pkg::CMS_EDGE || !q.dir)
		|=> q.cnt == '0 && q.psc_cnt == '0)
		else $error("slave reset did not clear counter");

	c_capture: cover property (cap[0]);
	c_overcapture: cover property (cap[1] && q.ccif[1]);
	c_rep_update: cover property (hw_upd && q.rep_val != '0);
	c_slave_reset: cover property (slv_rst && cap[0]);

endmodule : trc_timer_core

// ==== verification/tb_timer_repetition_capture_unit.sv ====
// Purpose: Register-level tests of repetition, clock select and capture
// Assumes: Input model supplies a pulse train on channel 1 input
// Notes:   Captured values expect counter reset on the trigger edge
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_timer_repetition_capture_unit;
	logic        clk_sys, arst_n, wr_s, rd_s, run;
	logic [7:0]  addr, hi_len, lo_len;
	logic [31:0] wdata, rdata, d, v;
	logic [1:0]  ti, ch_irq, ch_dma, oc;
	logic [3:0]  itrig;
	logic        ext_trigger_pin, upd_ev, upd_irq, upd_dma;
	int          n_fail, cmp_count, n, c0;

	trc_timer_core dut_u (.CLK_SYS(clk_sys), .ARST_N(arst_n), .ADDR(addr),
		.WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata), .TI(ti),
		.ETR_PIN(ext_trigger_pin), .ITRIG(itrig), .UPDATE_EVENT(upd_ev),
		.UPD_IRQ(upd_irq), .UPD_DMA(upd_dma), .CH_IRQ(ch_irq),
		.CH_DMA(ch_dma), .OC(oc));
	trc_input_model src_u (.clk(clk_sys), .arst_n(arst_n), .run(run),
		.hi_len(hi_len), .lo_len(lo_len), .ti(ti), .ext_trigger_pin(ext_trigger_pin),
		.itrig(itrig));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		@(posedge clk_sys);
		addr  <= a;
		wdata <= x;
		wr_s  <= 1'b1;
		@(posedge clk_sys);
		wr_s <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] x);
		@(posedge clk_sys);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_sys);
		rd_s <= 1'b0;
		#1 x = rdata;
	endtask : rd

	// Cycles until the next update pulse, bounded
	task automatic wait_ue(output int k);
		k = 0;
		do begin
			@(posedge clk_sys);
			#1 k++;
		end while (upd_ev !== 1'b1 && k < 2000);
	endtask : wait_ue

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run

	initial begin
		repeat (50000) @(posedge clk_sys);
		n_fail++;
		complete_run();
	end

	logic [31:0] ctl_t [3] = '{32'h1, 32'h3, 32'h5};
	logic [31:0] rep_t [3] = '{32'h2, 32'h1, 32'h3};
	int          exp_t [3] = '{12, 8, 12};
	logic [31:0] ext_t [3] = '{32'h57, 32'h80, 32'h07};

	initial begin
		{arst_n, wr_s, rd_s, run} = 4'h0;
		{addr, hi_len, lo_len} = 24'h0;
		wdata = 32'h0;
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		rd(trc_pkg::OFS_CTRL, d); `CHK(d, 32'h0)
		rd(8'hfc, d); `CHK(d, 32'h0)
		rd(trc_pkg::OFS_REP, d); `CHK(d, 32'h0)
		// Forced update with flag, then with flag suppressed
		wr(trc_pkg::OFS_IEN, 32'h303);
		wr(trc_pkg::OFS_PER, 32'h3);
		wr(trc_pkg::OFS_REP, 32'h2);
		wr(trc_pkg::OFS_EGEN, 32'h1);
		#1 `CHK(upd_ev, 1'b1)
		rd(trc_pkg::OFS_STAT, d); `CHK(d[trc_pkg::B_UIF], 1'b1)
		`CHK({upd_irq, upd_dma}, 2'h3)
		rd(trc_pkg::OFS_EGEN, d); `CHK(d, 32'h0)
		wr(trc_pkg::OFS_STAT, 32'h0);
		rd(trc_pkg::OFS_STAT, d); `CHK(d[trc_pkg::B_UIF], 1'b0)
		`CHK(upd_irq, 1'b0)
		wr(trc_pkg::OFS_CTRL, 32'h1 << trc_pkg::B_URS);
		wr(trc_pkg::OFS_EGEN, 32'h1);
		#1 `CHK(upd_ev, 1'b1)
		rd(trc_pkg::OFS_STAT, d); `CHK(d[trc_pkg::B_UIF], 1'b0)
		rd(trc_pkg::OFS_CNT, d); `CHK(d, 32'h0)
		// Update spacing in up, down and center counting
		for (int i = 0; i < 3; i++) begin
			wr(trc_pkg::OFS_CTRL, 32'h0);
			wr(trc_pkg::OFS_REP, rep_t[i]);
			wr(trc_pkg::OFS_EGEN, 32'h1);
			wr(trc_pkg::OFS_CTRL, ctl_t[i]);
			wait_ue(n);
			wait_ue(n);
			wait_ue(n);
			`CHK(n, exp_t[i])
		end
		// Filtered capture on channel 1, cross capture on channel 2
		wr(trc_pkg::OFS_CTRL, 32'h0);
		wr(trc_pkg::OFS_PER, 32'hffff);
		wr(trc_pkg::OFS_EGEN, 32'h1);
		wr(trc_pkg::OFS_CTRL, 32'h1);
		wr(trc_pkg::OFS_CHCFG, 32'h3231);
		wr(trc_pkg::OFS_CHEN, 32'h31);
		wr(trc_pkg::OFS_STAT, 32'h0);
		@(posedge clk_sys);
		{run, hi_len, lo_len} <= {1'b1, 8'h06, 8'h14};
		repeat (100) @(posedge clk_sys);
		rd(trc_pkg::OFS_STAT, d); `CHK(d[2:1], 2'h0)
		`CHK(ch_irq, 2'h0)
		hi_len <= 8'h0c;
		repeat (100) @(posedge clk_sys);
		rd(trc_pkg::OFS_STAT, d); `CHK(d[trc_pkg::B_CCF], 1'b1)
		`CHK(d[trc_pkg::B_OVR], 1'b1)
		`CHK({ch_irq[0], ch_dma[0]}, 2'h3)
		@(posedge clk_sys);
		run <= 1'b0;
		repeat (40) @(posedge clk_sys);
		rd(trc_pkg::OFS_CH1, v);
		rd(trc_pkg::OFS_STAT, d); `CHK(d[trc_pkg::B_CCF], 1'b0)
		`CHK(d[trc_pkg::B_OVR], 1'b1)
		wr(trc_pkg::OFS_CH1, 32'habcd);
		rd(trc_pkg::OFS_CH1, d); `CHK(d, v)
		wr(trc_pkg::OFS_STAT, 32'h0);
		rd(trc_pkg::OFS_STAT, d); `CHK(d[trc_pkg::B_OVR], 1'b0)
		wr(trc_pkg::OFS_EGEN, 32'h1 << trc_pkg::B_CG);
		rd(trc_pkg::OFS_STAT, d); `CHK(d[trc_pkg::B_CCF], 1'b1)
		`CHK(ch_irq[0], 1'b1)
		// Period and high time with slave reset on channel 1 edge
		wr(trc_pkg::OFS_SLAVE, 32'h54);
		@(posedge clk_sys);
		run <= 1'b1;
		repeat (200) @(posedge clk_sys);
		rd(trc_pkg::OFS_CH1, d); `CHK(d, 32'd31)
		rd(trc_pkg::OFS_CH2, d); `CHK(d, 32'd11)
		// Input edges, trigger pin edges, trigger line edges, 32 apart
		for (int i = 0; i < 3; i++) begin
			wr(trc_pkg::OFS_SLAVE, ext_t[i]);
			rd(trc_pkg::OFS_CNT, d);
			c0 = int'(d);
			repeat (320) @(posedge clk_sys);
			rd(trc_pkg::OFS_CNT, d);
			n = int'(d) - c0;
			`CHK(n >= 9 && n <= 11, 1'b1)
		end
		// Compare reference on channel 1, then with inverted polarity
		wr(trc_pkg::OFS_SLAVE, 32'h0);
		wr(trc_pkg::OFS_CTRL, 32'h0);
		wr(trc_pkg::OFS_CHCFG, 32'h3200);
		wr(trc_pkg::OFS_CH1, 32'h5);
		rd(trc_pkg::OFS_CH1, d); `CHK(d, 32'h5)
		wr(trc_pkg::OFS_EGEN, 32'h1);
		@(posedge clk_sys);
		#1 `CHK(oc, 2'h1)
		wr(trc_pkg::OFS_CNT, 32'h7);
		@(posedge clk_sys);
		#1 `CHK(oc, 2'h0)
		wr(trc_pkg::OFS_CHEN, 32'h33);
		@(posedge clk_sys);
		#1 `CHK(oc, 2'h1)
		// Second reset in mid-run brings the request and compare outputs and the slave and channel enable fields back
		@(posedge clk_sys);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		#1 `CHK({oc, ch_irq, ch_dma, upd_irq, upd_dma}, 8'h0)
		rd(trc_pkg::OFS_SLAVE, d); `CHK(d, 32'h0)
		rd(trc_pkg::OFS_CHEN, d); `CHK(d, 32'h0)
		complete_run();
	end
endmodule : tb_timer_repetition_capture_unit

// ==== verification/trc_input_model.sv ====
// Purpose: Far-side source of channel input, trigger pin and trigger lines
// Assumes: Levels change right after a rising clock edge
// Notes:   Trigger pin runs free, one full period every 32 clocks
`timescale 1ns/10ps
module trc_input_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// Pulse train control
	input  wire logic       run,
	input  wire logic [7:0] hi_len,
	input  wire logic [7:0] lo_len,
	// Driven lines
	output logic      [1:0] ti,
	output logic            ext_trigger_pin,
	output logic      [3:0] itrig
);
	logic [7:0] cnt_q;
	logic       lvl_q;
	logic [3:0] ecnt_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q  <= 8'h00;
			lvl_q  <= 1'b0;
			ecnt_q <= 4'h0;
			ext_trigger_pin    <= 1'b0;
		end else begin
			ecnt_q <= ecnt_q + 4'h1;
			if (ecnt_q == 4'hf)
				ext_trigger_pin <= ~ext_trigger_pin;
			if (!run) begin
				cnt_q <= 8'h00;
				lvl_q <= 1'b0;
			end else if ({1'b0, cnt_q} + 9'h001 >=
					{1'b0, (lvl_q ? hi_len : lo_len)}) begin
				cnt_q <= 8'h00;
				lvl_q <= ~lvl_q;
			end else
				cnt_q <= cnt_q + 8'h01;
		end
	end

	// Unused second input still moves, so a wrong select shows up
	assign ti    = {~lvl_q, lvl_q};
	assign itrig = {3'h0, ext_trigger_pin};
endmodule : trc_input_model
